// [rtl/cpc_defs.vh]
// constants for the 16-bit core: data map, control bits, alu operations
// assumes word-addressed program memory and byte-addressed data space
//
// Function
// - program counter is 23 bits, covering 8M words of 24 bits
// - 24-bit instruction words; opcode width is found from leading bits
// - one cycle per instruction except flow change, double move, table read, window read
// - next instruction is fetched one cycle ahead of execution
// - repeat runs next instruction without overhead; interrupts may suspend it
// - sixteen 16-bit working registers usable as data, pointer or offset
// - register 15 is the stack pointer for calls and interrupt entry
// - one cycle holds memory read, register read, memory write and fetch
// - data space is 32K words, addressed as 64 Kbytes
// - upper 32 Kbytes map to program memory at page times 16K words
// - only table read and an alu instruction with indirect source reading the window get program memory as data
// - 2 Kbyte DMA RAM region, reachable by DMA and by the core
// - active-low external reset initialises the core registers; the data ram is not cleared
// - window mapping only when enable bit 2 of core control is set
// - status bit 4 reads 1 while a repeat loop runs
//////////////////////////////////////////////////////////////////////////////
`ifndef CPC_DEFS_VH
`define CPC_DEFS_VH

`define CPC_PC_W        23
`define CPC_IW          24
`define CPC_RESET_PC    23'h000000
`define CPC_IRQ_VEC     23'h000004
`define CPC_SP_RESET    16'h0800
// core registers in data space
`define CPC_PAGE_ADDR   16'h0034
`define CPC_SR_ADDR     16'h0042
`define CPC_CTRL_ADDR   16'h0044
`define CPC_SR_C        0
`define CPC_SR_Z        1
`define CPC_SR_N        3
`define CPC_SR_LOOP     4
`define CPC_CC_PWE      2
// data map
`define CPC_SFR_END     16'h07FF
`define CPC_RAM_BASE    16'h0800
`define CPC_RAM_END     16'h17FF
`define CPC_RAM_WORDS   2048
`define CPC_WIN_BASE    16'h8000
// alu operations
`define CPC_OP_MOV      4'h0
`define CPC_OP_ADD      4'h1
`define CPC_OP_SUB      4'h2
`define CPC_OP_AND      4'h3
`define CPC_OP_OR       4'h4
`define CPC_OP_XOR      4'h5

`endif

// [rtl/cpc_agen.v]
// address generator: decodes a data-space byte address into a target
// assumes word accesses; address bit 0 is ignored
`timescale 1ns/1ns
`include "cpc_defs.vh"

module cpc_agen (
   input  wire [15:0] addr,
   input  wire        win_en,
   input  wire [7:0]  page,
   output wire        sel_sfr,
   output wire        sel_ram,
   output wire        sel_win,
   output wire [10:0] ram_idx,
   output wire [22:0] win_addr
);

   wire [15:0] ram_off;

   //////////////////////////////////////////////////////////////////////////
   // region decode over the linear 64 Kbyte space
   assign sel_sfr = (addr <= `CPC_SFR_END);
   assign sel_ram = (addr >= `CPC_RAM_BASE) && (addr <= `CPC_RAM_END);
   assign sel_win = win_en && (addr >= `CPC_WIN_BASE);
   assign ram_off = addr - `CPC_RAM_BASE;
   assign ram_idx = ram_off[11:1];
   // window word = page * 16K + offset within upper half
   assign win_addr = {1'b0, page, addr[14:1]};

endmodule

// [rtl/cpc_core.v]
// execution and data-addressing frame of the 16-bit core
// assumes asynchronous-read program memory and same-clock dma and irq inputs
`timescale 1ns/1ns
`include "cpc_defs.vh"

module cpc_core (
   input  wire        clk,
   input  wire        rst_n,
   output reg  [22:0] prog_addr,
   input  wire [23:0] prog_rd_data,
   output reg  [22:0] pwin_addr,
   input  wire [23:0] pwin_rd_data,
   input  wire        irq_req,
   output reg         irq_ack,
   output reg         loop_active_flag,
   input  wire        dma_en,
   input  wire        dma_we,
   input  wire [9:0]  dma_addr,
   input  wire [15:0] dma_wdata,
   output reg  [15:0] dma_rdata
);

   localparam ST_RUN  = 5'b00001;
   localparam ST_WIN  = 5'b00010;
   localparam ST_PUSH = 5'b00100;
   localparam ST_POP  = 5'b01000;
   localparam ST_MOVD = 5'b10000;

   reg  [23:0] ir;
   reg  [22:0] ir_pc;
   reg         ir_valid;
   reg  [4:0]  state;
   reg  [15:0] w [0:15];
   reg  [15:0] data_ram [0:`CPC_RAM_WORDS-1];
   reg         sr_c;
   reg         sr_z;
   reg         sr_n;
   reg         program_window_enable;
   reg  [7:0]  program_window_page;
   reg  [13:0] rcount;
   reg         loop_held;
   reg         in_isr;
   reg  [22:0] ret_pc;
   reg  [22:0] tgt_pc;
   reg  [15:0] ret_hi;
   reg  [15:0] movd_addr;
   reg  [15:0] rd_addr;
   reg  [15:0] wr_addr;
   reg  [15:0] wr_data;
   reg  [16:0] res;
   integer     i;

   wire        rd_sfr, rd_ram, rd_win, wr_sfr, wr_ram;
   wire [10:0] rd_idx, wr_idx;
   wire [22:0] rd_waddr;

   //////////////////////////////////////////////////////////////////////////
   // opcode class from the leading bits of the word
   function [7:0] cpc_class;
      input [23:0] iw;
      begin
         casez (iw[23:20])
            4'b00??: cpc_class = 8'h01;                  // alu
            4'b010?: cpc_class = 8'h02;                  // load literal
            4'b0110: cpc_class = 8'h04;                  // relative jump
            4'b0111: cpc_class = 8'h08;                  // call
            4'b1000: cpc_class = 8'h10;                  // return
            4'b1001: cpc_class = 8'h20;                  // repeat
            4'b1010: cpc_class = 8'h40;                  // double_word_move
            4'b1011: cpc_class = 8'h80;                  // table read
            default: cpc_class = 8'h00;                  // no operation
         endcase
      end
   endfunction

   // core register read-back
   function [15:0] sfr_rd;
      input [15:0] a;
      input        lpf, n, z, c, pwe;
      input [7:0]  pg;
      begin
         case (a)
            `CPC_SR_ADDR:     sfr_rd = {11'h000, lpf, n, 1'b0, z, c};
            `CPC_CTRL_ADDR:   sfr_rd = {13'h0000, pwe, 2'b00};
            `CPC_PAGE_ADDR:   sfr_rd = {8'h00, pg};
            default:          sfr_rd = 16'h0000;
         endcase
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // decode of the instruction held in the prefetch register
   wire [7:0]  cls     = cpc_class(ir);
   wire [3:0]  f_wd    = ir[17:14];
   wire [3:0]  f_ws    = ir[13:10];
   wire [3:0]  f_wb    = ir[9:6];
   wire [3:0]  f_wo    = ir[3:0];
   wire        src_ind = ir[5];
   wire        dst_ind = ir[4];
   wire [15:0] sp      = w[15];
   wire [22:0] rel_tgt = ir_pc + {{3{ir[19]}}, ir[19:0]};
   wire        st_run  = state[0];
   wire        st_win  = state[1];
   wire        st_push = state[2];
   wire        st_pop  = state[3];
   wire        st_movd = state[4];

   // address generation for the read and the write of one cycle
   always @*
   begin
      if (st_movd)
         rd_addr = movd_addr;
      else if (cls[4] || st_pop)
         rd_addr = sp - 16'h0002;
      else
         rd_addr = w[f_wb] + w[f_wo];
   end

   cpc_agen u_rd (
      .addr     (rd_addr),
      .win_en   (program_window_enable),
      .page     (program_window_page),
      .sel_sfr  (rd_sfr),
      .sel_ram  (rd_ram),
      .sel_win  (rd_win),
      .ram_idx  (rd_idx),
      .win_addr (rd_waddr)
   );

   cpc_agen u_wr (
      .addr     (wr_addr),
      .win_en   (program_window_enable),
      .page     (program_window_page),
      .sel_sfr  (wr_sfr),
      .sel_ram  (wr_ram),
      .sel_win  (),
      .ram_idx  (wr_idx),
      .win_addr ()
   );

   // memory operand; unimplemented space reads zero
   wire [15:0] rd_mem = rd_ram ? data_ram[rd_idx] :
                        rd_sfr ? sfr_rd(rd_addr, loop_active_flag, sr_n,
                                        sr_z, sr_c, program_window_enable,
                                        program_window_page) :
                        16'h0000;
   wire [15:0] src_b  = st_win  ? pwin_rd_data[15:0] :
                        src_ind ? rd_mem : w[f_wb];

   // sequencing terms
   wire irq_take = st_run & ir_valid & irq_req & ~in_isr;
   wire go       = st_run & ir_valid & ~irq_take;
   wire need_win = cls[7] | (cls[0] & src_ind & rd_win);
   wire commit   = st_win | (go & ~need_win & (cls[0] | cls[1] | ~|cls));
   wire hold     = loop_active_flag & (rcount != 14'h0000);
   wire push_lo  = irq_take | (go & cls[3]);
   wire mem_we   = push_lo | st_push | (commit & cls[0] & dst_ind);
   // fetch moves on once the current word finishes, unless it changes flow or the loop holds it
   wire adv      = (st_run & ~ir_valid) | (commit & ~hold) |
                   (go & cls[5]) | st_movd;

   //////////////////////////////////////////////////////////////////////////
   // alu result and write port data
   always @*
   begin
      case (ir[21:18])
         `CPC_OP_ADD: res = {1'b0, w[f_ws]} + {1'b0, src_b};
         `CPC_OP_SUB: res = {1'b0, w[f_ws]} - {1'b0, src_b};
         `CPC_OP_AND: res = {1'b0, w[f_ws] & src_b};
         `CPC_OP_OR:  res = {1'b0, w[f_ws] | src_b};
         `CPC_OP_XOR: res = {1'b0, w[f_ws] ^ src_b};
         default:     res = {1'b0, src_b};
      endcase
      if (cls[7])
         res = {1'b0, src_b};
      if (push_lo || st_push)
         wr_addr = sp;
      else
         wr_addr = w[f_wd];
      if (irq_take)
         wr_data = ir_pc[15:0];
      else if (push_lo)
         wr_data = prog_addr[15:0];
      else if (st_push)
         wr_data = {9'h000, ret_pc[22:16]};
      else
         wr_data = res[15:0];
   end

   //////////////////////////////////////////////////////////////////////////
   // data ram with dma port in its upper 1K words; core write wins
   always @(posedge clk)
   begin
      if (dma_en && dma_we)
         data_ram[{1'b1, dma_addr}] <= dma_wdata;
      if (mem_we && wr_ram)
         data_ram[wr_idx] <= wr_data;
   end

   // dma read data
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dma_rdata <= 16'h0000;
      else if (dma_en && !dma_we)
         dma_rdata <= data_ram[{1'b1, dma_addr}];
   end

   //////////////////////////////////////////////////////////////////////////
   // program counter, prefetch, state, registers and loop control
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prog_addr             <= `CPC_RESET_PC;
         ir                    <= 24'h000000;
         ir_pc                 <= 23'h000000;
         ir_valid              <= 1'b0;
         state                 <= ST_RUN;
         for (i = 0; i < 15; i = i + 1)
            w[i] <= 16'h0000;
         w[15]                 <= `CPC_SP_RESET;
         sr_c                  <= 1'b0;
         sr_z                  <= 1'b0;
         sr_n                  <= 1'b0;
         program_window_enable <= 1'b0;
         program_window_page   <= 8'h00;
         rcount                <= 14'h0000;
         loop_active_flag      <= 1'b0;
         loop_held             <= 1'b0;
         in_isr                <= 1'b0;
         ret_pc                <= 23'h000000;
         tgt_pc                <= 23'h000000;
         ret_hi                <= 16'h0000;
         movd_addr             <= 16'h0000;
         pwin_addr             <= 23'h000000;
         irq_ack               <= 1'b0;
      end
      else
      begin
         irq_ack <= irq_take;
         // single-stage prefetch: word at pc becomes next to run
         if (adv)
         begin
            ir        <= prog_rd_data;
            ir_pc     <= prog_addr;
            prog_addr <= prog_addr + 23'h000001;
            ir_valid  <= 1'b1;
         end
         // finished single-cycle work: results and loop count
         if (commit)
         begin
            state <= ST_RUN;
            if ((cls[0] && !dst_ind) || cls[7])
               w[f_wd] <= res[15:0];
            if (cls[1])
               w[ir[19:16]] <= ir[15:0];
            if (cls[0])
            begin
               sr_c <= res[16];
               sr_z <= (res[15:0] == 16'h0000);
               sr_n <= res[15];
            end
            if (hold)
               rcount <= rcount - 14'h0001;
            else
               loop_active_flag <= 1'b0;
         end
         // program window or table read costs one wait cycle
         if (go && need_win)
         begin
            pwin_addr <= cls[7] ? {program_window_page, w[f_wb][15:1]}
                                : rd_waddr;
            state     <= ST_WIN;
         end
         if (go && cls[2])
         begin
            prog_addr <= rel_tgt;
            ir_valid  <= 1'b0;
         end
         if (go && cls[5])
         begin
            rcount           <= ir[13:0];
            loop_active_flag <= 1'b1;
         end
         if (go && cls[6])
         begin
            w[f_wd]   <= rd_mem;
            movd_addr <= rd_addr + 16'h0002;
            state     <= ST_MOVD;
         end
         if (st_movd)
         begin
            w[f_wd + 4'h1] <= rd_mem;
            state          <= ST_RUN;
         end
         // call and interrupt entry push low word, then high
         if (go && cls[3])
         begin
            ret_pc <= prog_addr;
            tgt_pc <= rel_tgt;
            state  <= ST_PUSH;
         end
         if (irq_take)
         begin
            ret_pc <= ir_pc;
            tgt_pc <= `CPC_IRQ_VEC;
            in_isr <= 1'b1;
            state  <= ST_PUSH;
            if (loop_active_flag)
            begin
               loop_held        <= 1'b1;
               loop_active_flag <= 1'b0;
            end
         end
         if (push_lo || st_push)
            w[15] <= sp + 16'h0002;
         if (st_push)
         begin
            prog_addr <= tgt_pc;
            ir_valid  <= 1'b0;
            state     <= ST_RUN;
         end
         // return pops high word, then low; bit 0 ends interrupt
         if (go && cls[4])
         begin
            ret_hi <= rd_mem;
            w[15]  <= sp - 16'h0002;
            state  <= ST_POP;
         end
         if (st_pop)
         begin
            w[15]     <= sp - 16'h0002;
            prog_addr <= {ret_hi[6:0], rd_mem};
            ir_valid  <= 1'b0;
            state     <= ST_RUN;
            if (ir[0])
            begin
               in_isr           <= 1'b0;
               loop_active_flag <= loop_held;
               loop_held        <= 1'b0;
            end
         end
         // core register writes through data space
         if (mem_we && wr_sfr)
         begin
            case (wr_addr)
               `CPC_SR_ADDR:
               begin
                  sr_c <= wr_data[`CPC_SR_C];
                  sr_z <= wr_data[`CPC_SR_Z];
                  sr_n <= wr_data[`CPC_SR_N];
               end
               `CPC_CTRL_ADDR:
                  program_window_enable <= wr_data[`CPC_CC_PWE];
               `CPC_PAGE_ADDR:
                  program_window_page <= wr_data[7:0];
               default:
                  sr_c <= sr_c;
            endcase
         end
      end
   end

endmodule

// [tb/cpc_core_chk.sv]
// checker for the core: reset fetch, interrupt entry and dma port timing
// assumes it is bound to cpc_core and sees only that module's ports
`timescale 1ns/1ns
module cpc_core_chk (
   input wire        clk,
   input wire        rst_n,
   input wire [22:0] prog_addr,
   input wire        irq_req,
   input wire        irq_ack,
   input wire        loop_active_flag,
   input wire        dma_en,
   input wire        dma_we,
   input wire [9:0]  dma_addr,
   input wire [15:0] dma_wdata,
   input wire [15:0] dma_rdata
);
   //////////////////////////////////////////////////////////////////////////
   // one clock domain, reset disables every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // first sampled edge with reset released
   sequence s_release;
      $rose(rst_n);
   endsequence
   // vector word fetched, then the fetch moves on
   sequence s_vector_fetch;
      prog_addr == 23'h4 ##1 prog_addr == 23'h5;
   endsequence
   // dma write followed at once by a read of the same word
   sequence s_wr_rd;
      dma_en && dma_we ##1 dma_en && !dma_we && dma_addr == $past(dma_addr);
   endsequence

   //////////////////////////////////////////////////////////////////////////
   a_reset_fetch: assert property (s_release |-> prog_addr == 23'h0
      ##1 prog_addr == 23'h1) else $error("fetch after reset wrong");
   a_reset_quiet: assert property (s_release |-> !irq_ack
      && !loop_active_flag && dma_rdata == 16'h0)
      else $error("outputs not cleared by reset");
   a_ack_cause: assert property (irq_ack |-> $past(irq_req))
      else $error("interrupt accepted without request");
   a_irq_vector: assert property (irq_ack |=> s_vector_fetch)
      else $error("interrupt entry did not fetch the vector");
   a_ack_single: assert property (irq_ack |=> !irq_ack [*3])
      else $error("interrupt accepted again inside handler");
   a_irq_flag: assert property (irq_ack |=> !loop_active_flag)
      else $error("loop flag high inside handler");
   a_dma_hold: assert property (!(dma_en && !dma_we) |=>
      $stable(dma_rdata)) else $error("dma read data moved without read");
   a_dma_readback: assert property (s_wr_rd |=>
      dma_rdata == $past(dma_wdata, 2)) else $error("dma readback wrong");
endmodule

bind cpc_core cpc_core_chk cpc_core_chk_i (
   .clk              (clk),
   .rst_n            (rst_n),
   .prog_addr        (prog_addr),
   .irq_req          (irq_req),
   .irq_ack          (irq_ack),
   .loop_active_flag (loop_active_flag),
   .dma_en           (dma_en),
   .dma_we           (dma_we),
   .dma_addr         (dma_addr),
   .dma_wdata        (dma_wdata),
   .dma_rdata        (dma_rdata)
);

// [tb/cpc_core_tb.sv]
// self-checking bench for the core: small programs, results read over dma
// assumes async program and window memories, modelled here as an array and a pattern function
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module cpc_core_tb;
   reg         clk;
   reg         rst_n;
   wire [22:0] prog_addr;
   wire [23:0] prog_rd_data;
   wire [22:0] pwin_addr;
   wire [23:0] pwin_rd_data;
   reg         irq_req;
   wire        irq_ack;
   wire        loop_active_flag;
   reg         dma_en;
   reg         dma_we;
   reg  [9:0]  dma_addr;
   reg  [15:0] dma_wdata;
   wire [15:0] dma_rdata;
   reg  [23:0] prog [0:63];
   integer     n_fail;
   integer     n_checks;
   integer     i;
   localparam [95:0] ALU_EXP = {16'h1D3B, 16'h1F3F, 16'h0204, 16'h0325,
                                16'h2143, 16'h0F0F};

   //////////////////////////////////////////////////////////////////////////
   // memories: program array and an address-derived window pattern
   function [23:0] win_word(input [22:0] a);
      win_word = {a[7:0], a[15:0] ^ 16'h5A3C};
   endfunction
   assign prog_rd_data = prog[prog_addr[5:0]];
   assign pwin_rd_data = win_word(pwin_addr);

   cpc_core cpc_core_i (
      .clk              (clk),
      .rst_n            (rst_n),
      .prog_addr        (prog_addr),
      .prog_rd_data     (prog_rd_data),
      .pwin_addr        (pwin_addr),
      .pwin_rd_data     (pwin_rd_data),
      .irq_req          (irq_req),
      .irq_ack          (irq_ack),
      .loop_active_flag (loop_active_flag),
      .dma_en           (dma_en),
      .dma_we           (dma_we),
      .dma_addr         (dma_addr),
      .dma_wdata        (dma_wdata),
      .dma_rdata        (dma_rdata)
   );

   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   //////////////////////////////////////////////////////////////////////////
   // instruction builders and shared tasks
   function [23:0] li(input [3:0] r, input [15:0] v);
      li = {4'h4, r, v};
   endfunction
   function [23:0] al(input [3:0] op, wd, ws, wb, input si, di);
      al = {2'b00, op, wd, ws, wb, si, di, 4'h0};
   endfunction
   task run(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task clr;
      for (i = 0; i < 64; i++) prog[i] = 24'hF00000;
   endtask
   task start;
      begin
         rst_n = 0;
         run(8);
         `CHK("prog_addr in reset", 23'h0, prog_addr)
         rst_n = 1;
      end
   endtask
   task chk_dma(input [9:0] a, input [15:0] e);
      begin
         dma_en = 1;
         dma_we = 0;
         dma_addr = a;
         @(negedge clk);
         dma_en = 0;
         @(negedge clk);
         `CHK("dma word", e, dma_rdata)
      end
   endtask

   //////////////////////////////////////////////////////////////////////////
   // every alu op, three operands, one cycle each
   task t_alu;
      begin
         clr;
         prog[0] = li(4'h1, 16'h1234);
         prog[1] = li(4'h2, 16'h0F0F);
         for (i = 0; i < 6; i++)
         begin
            prog[2 + 2 * i] = li(4'h3, 16'h1000 + 16'(2 * i));
            prog[3 + 2 * i] = al(i[3:0], 4'h3, 4'h1, 4'h2, 1'b0, 1'b1);
         end
         prog[14] = 24'h600000;
         start;
         run(14);
         `CHK("prog_addr", 23'd14, prog_addr)
         for (i = 0; i < 6; i++)
            chk_dma(i[9:0], ALU_EXP[16 * i +: 16]);
         $display("test alu done");
      end
   endtask

   // window read with mapping off, then on with page 3
   task t_win;
      begin
         clr;
         prog[0] = li(4'h7, 16'h0034);
         prog[1] = li(4'h8, 16'h0003);
         prog[2] = al(4'h0, 4'h7, 4'h0, 4'h8, 1'b0, 1'b1);
         prog[3] = li(4'h9, 16'h8006);
         prog[4] = li(4'h3, 16'h1000);
         prog[5] = al(4'h0, 4'h3, 4'h0, 4'h9, 1'b1, 1'b1);
         prog[6] = li(4'h5, 16'h0044);
         prog[7] = li(4'h6, 16'h0004);
         prog[8] = al(4'h0, 4'h5, 4'h0, 4'h6, 1'b0, 1'b1);
         prog[9] = li(4'h3, 16'h1002);
         prog[10] = al(4'h0, 4'h3, 4'h0, 4'h9, 1'b1, 1'b1);
         prog[11] = 24'h600000;
         start;
         run(30);
         `CHK("pwin_addr", 23'h00C003, pwin_addr)
         chk_dma(10'h000, 16'h0000);
         chk_dma(10'h001, 16'h9A3F);
         $display("test window done");
      end
   endtask

   // call and return through the stack pointer
   task t_call;
      begin
         clr;
         prog[0] = li(4'h3, 16'h1004);
         prog[1] = 24'h700004;
         prog[2] = al(4'h0, 4'h3, 4'h0, 4'hF, 1'b0, 1'b1);
         prog[3] = 24'h600000;
         prog[5] = li(4'h4, 16'h1006);
         prog[6] = al(4'h0, 4'h4, 4'h0, 4'hF, 1'b0, 1'b1);
         prog[7] = li(4'hA, 16'h0800);
         prog[8] = li(4'h4, 16'h1008);
         prog[9] = al(4'h0, 4'h4, 4'h0, 4'hA, 1'b1, 1'b1);
         prog[10] = 24'h800000;
         start;
         run(40);
         chk_dma(10'h002, 16'h0800);
         chk_dma(10'h003, 16'h0804);
         chk_dma(10'h004, 16'h0002);
         $display("test call done");
      end
   endtask

   // repeat loop suspended by an interrupt, count must survive
   task t_loop;
      begin
         clr;
         prog[0] = 24'h600008;
         prog[4] = al(4'h1, 4'hC, 4'hC, 4'h1, 1'b0, 1'b0);
         prog[5] = 24'h800001;
         prog[8] = li(4'h1, 16'h0001);
         prog[9] = 24'h900009;
         prog[10] = al(4'h1, 4'h2, 4'h2, 4'h1, 1'b0, 1'b0);
         prog[11] = li(4'h3, 16'h100A);
         prog[12] = al(4'h0, 4'h3, 4'h0, 4'h2, 1'b0, 1'b1);
         prog[13] = li(4'h3, 16'h100C);
         prog[14] = al(4'h0, 4'h3, 4'h0, 4'hC, 1'b0, 1'b1);
         prog[15] = 24'h600000;
         start;
         for (i = 0; i < 40 && loop_active_flag !== 1'b1; i++) run(1);
         `CHK("loop flag", 1'b1, loop_active_flag)
         run(2);
         irq_req = 1;
         for (i = 0; i < 10 && irq_ack !== 1'b1; i++) run(1);
         `CHK("irq_ack", 1'b1, irq_ack)
         irq_req = 0;
         run(1);
         `CHK("loop flag", 1'b0, loop_active_flag)
         run(40);
         chk_dma(10'h005, 16'h000A);
         chk_dma(10'h006, 16'h0001);
         $display("test loop done");
      end
   endtask

   // dma write, readback, then the core copies the word
   task t_dma;
      begin
         clr;
         prog[0] = li(4'h3, 16'h17FE);
         prog[1] = li(4'h4, 16'h1010);
         prog[6] = al(4'h0, 4'h4, 4'h0, 4'h3, 1'b1, 1'b1);
         prog[7] = 24'h600000;
         start;
         dma_en = 1;
         dma_we = 1;
         dma_addr = 10'h3FF;
         dma_wdata = 16'hBEEF;
         run(1);
         dma_we = 0;
         run(1);
         dma_en = 0;
         `CHK("dma readback", 16'hBEEF, dma_rdata)
         run(20);
         chk_dma(10'h008, 16'hBEEF);
         $display("test dma done");
      end
   endtask

   // loop bit in status, negative flag, double_word_move, table read
   task t_more;
      begin
         clr;
         prog[0] = li(4'h1, 16'h0044);
         prog[1] = li(4'h2, 16'h0004);
         prog[2] = al(4'h0, 4'h1, 4'h0, 4'h2, 1'b0, 1'b1);
         prog[3] = li(4'h3, 16'h0034);
         prog[4] = li(4'h4, 16'h0005);
         prog[5] = al(4'h0, 4'h3, 4'h0, 4'h4, 1'b0, 1'b1);
         prog[6] = li(4'h5, 16'h0042);
         prog[7] = li(4'h6, 16'h1020);
         prog[8] = 24'h900000;
         prog[9] = al(4'h0, 4'h6, 4'h0, 4'h5, 1'b1, 1'b1);
         prog[10] = li(4'hC, 16'h8000);
         prog[11] = al(4'h0, 4'hD, 4'h0, 4'hC, 1'b0, 1'b0);
         prog[12] = al(4'h0, 4'h8, 4'h0, 4'h5, 1'b0, 1'b0) | 24'hA00000;
         prog[13] = li(4'hA, 16'h000A);
         prog[14] = al(4'h0, 4'hB, 4'h0, 4'hA, 1'b0, 1'b0) | 24'hB00000;
         prog[15] = li(4'h7, 16'h1022);
         prog[16] = al(4'h0, 4'h7, 4'h0, 4'h8, 1'b0, 1'b1);
         prog[17] = li(4'h7, 16'h1024);
         prog[18] = al(4'h0, 4'h7, 4'h0, 4'h9, 1'b0, 1'b1);
         prog[19] = li(4'h7, 16'h1026);
         prog[20] = al(4'h0, 4'h7, 4'h0, 4'hB, 1'b0, 1'b1);
         prog[21] = 24'h600000;
         start;
         run(45);
         `CHK("pwin_addr", 23'h028005, pwin_addr)
         chk_dma(10'h010, 16'h0010);
         chk_dma(10'h011, 16'h0008);
         chk_dma(10'h012, 16'h0004);
         chk_dma(10'h013, 16'hDA39);
         $display("test more done");
      end
   endtask

   //////////////////////////////////////////////////////////////////////////
   // verdict and run control
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial
   begin
      #50000;
      $display("unexpected watchdog exp done got hang");
      n_fail = n_fail + 1;
      final_report;
   end

   initial
   begin
      n_fail = 0;
      n_checks = 0;
      irq_req = 0;
      dma_en = 0;
      dma_we = 0;
      dma_addr = 10'h000;
      dma_wdata = 16'h0000;
      t_alu;
      t_win;
      t_call;
      t_loop;
      t_dma;
      t_more;
      final_report;
   end
endmodule
